// *** rtl/psos_pkg.sv ***
package psos_pkg;

    // Clock and millisecond tick
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int TICK_W = 18;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DLY1P = 8'h08;
    localparam logic [7:0] OFS_DLY1R = 8'h0C;
    localparam logic [7:0] OFS_DLY2P = 8'h10;
    localparam logic [7:0] OFS_DLY3P = 8'h14;
    localparam logic [7:0] OFS_DLY4P = 8'h18;
    localparam logic [7:0] OFS_SEAL = 8'h1C;
    localparam logic [7:0] OFS_ANG_OUT = 8'h20;
    localparam logic [7:0] OFS_ANG_MID = 8'h24;
    localparam logic [7:0] OFS_ANG_IN = 8'h28;
    localparam logic [7:0] OFS_BLD0 = 8'h30;
    localparam int NUM_BLD = 6;

    // Control fields
    localparam int CTRL_W = 5;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_THREE_BIT = 1;
    localparam int CTRL_EARLY_BIT = 2;
    localparam int CTRL_EVT_BIT = 3;
    localparam int CTRL_QUAD_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h08;

    // Status fields
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_TRIP_BIT = 1;
    localparam int ST_SEAL_BIT = 2;
    localparam int ST_PKP1_BIT = 3;
    localparam int ST_PKP2_BIT = 4;
    localparam int ST_PKP3_BIT = 5;
    localparam int ST_PKP4_BIT = 6;
    localparam int ST_ARMED_BIT = 7;
    localparam int ST_STATE_LSB = 8;
    localparam int EVT_W = 8;

    // Timer settings in milliseconds
    localparam logic [15:0] DLY1P_RST = 16'h001E;
    localparam logic [15:0] DLY1R_RST = 16'h0032;
    localparam logic [15:0] DLY2P_RST = 16'h0011;
    localparam logic [15:0] DLY3P_RST = 16'h0009;
    localparam logic [15:0] DLY4P_RST = 16'h0011;
    localparam logic [15:0] SEAL_RST = 16'h0190;

    // Limit angles in degrees
    localparam logic [7:0] ANG_OUT_RST = 8'h78;
    localparam logic [7:0] ANG_MID_RST = 8'h5A;
    localparam logic [7:0] ANG_IN_RST = 8'h3C;
    localparam logic [7:0] ANG_MIN = 8'h28;
    localparam logic [7:0] ANG_MAX = 8'h8C;
    localparam logic [7:0] ANG_RIGHT = 8'h5A;

    // Blinder reaches in hundredths of an ohm
    localparam logic [15:0] BLD_RST = 16'h03E8;
    localparam logic [15:0] BLD_MIN = 16'h000A;
    localparam logic [15:0] BLD_MAX = 16'hC350;

    typedef enum logic [2:0] {S_IDLE, S_MID, S_IN, S_ARM, S_ARM_EXIT} psos_state_e;

endpackage

// *** rtl/psos_seq.sv ***
`timescale 1ns/1ps
`default_nettype none

module psos_seq #(
    parameter int TICK_CYCLES = psos_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic zone_outer,
    input wire logic zone_middle,
    input wire logic zone_inner,
    input wire logic supv_ok,
    input wire logic block_in,
    output logic swing_block,
    output logic oos_trip,
    output logic evt_valid,
    output logic [7:0] evt_code,
    output logic shape_quad,
    output logic outer_apple,
    output logic [7:0] ang_outer,
    output logic [7:0] ang_middle,
    output logic [7:0] ang_inner,
    output logic [psos_pkg::NUM_BLD-1:0][15:0] blinder_reach
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [psos_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
        logic [psos_pkg::CTRL_W-1:0] ctrl;
        logic [15:0] dly1p;
        logic [15:0] dly1r;
        logic [15:0] dly2p;
        logic [15:0] dly3p;
        logic [15:0] dly4p;
        logic [15:0] seal;
        logic [7:0] ang_out;
        logic [7:0] ang_mid;
        logic [7:0] ang_in;
        logic [psos_pkg::NUM_BLD-1:0][15:0] bld;
        logic latch;
        logic [15:0] t1;
        logic [15:0] t1r;
        logic [15:0] tseq;
        logic [15:0] tseal;
        logic seal_on;
        psos_pkg::psos_state_e st;
        logic trip;
        logic trip_out;
        logic [7:0] evt_prev;
        logic evt_valid;
        logic [7:0] evt_code;
    } psos_regs_s;

    psos_regs_s q_q;
    psos_regs_s q_d;

    logic en;
    logic three;
    logic z_out;
    logic z_mid;
    logic z_in;
    logic band1;
    logic band2;
    logic band4;
    logic pk1;
    logic pk2;
    logic pk3;
    logic pk4;
    logic armed;
    logic [15:0] status;
    logic req;
    logic wr;
    logic [7:0] boff;
    logic bld_hit;
    logic [31:0] rdv;
    logic [31:0] wv;

    // Saturating millisecond counter, zero when its condition drops
    function automatic logic [15:0] tmr(input logic run, input logic [15:0] cnt, input logic tick);
        logic [15:0] r;
        r = cnt;
        if (!run)
        begin
            r = 16'h0000;
        end
        else if (tick && cnt != 16'hFFFF)
        begin
            r = cnt + 16'h0001;
        end
        return r;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign en = q_q.ctrl[psos_pkg::CTRL_EN_BIT];
    assign three = q_q.ctrl[psos_pkg::CTRL_THREE_BIT];

    assign z_out = en & supv_ok & zone_outer;
    assign z_in = en & supv_ok & zone_inner;
    assign z_mid = en & supv_ok & zone_middle & three;

    assign band1 = z_out & ~(three ? z_mid : z_in);
    assign band2 = z_mid & ~z_in;
    assign band4 = z_out & ~z_in;

    assign pk1 = band1 && q_q.t1 >= q_q.dly1p;
    assign pk2 = q_q.st == psos_pkg::S_MID && band2 && q_q.tseq >= q_q.dly2p;
    assign pk3 = q_q.st == psos_pkg::S_IN && z_in && q_q.tseq >= q_q.dly3p;
    assign pk4 = q_q.st == psos_pkg::S_ARM && band4 && q_q.tseq >= q_q.dly4p;
    assign armed = q_q.st == psos_pkg::S_ARM || q_q.st == psos_pkg::S_ARM_EXIT;

    always_comb
    begin
        status = 16'h0000;
        status[psos_pkg::ST_LATCH_BIT] = q_q.latch;
        status[psos_pkg::ST_TRIP_BIT] = q_q.trip_out;
        status[psos_pkg::ST_SEAL_BIT] = q_q.seal_on;
        status[psos_pkg::ST_PKP1_BIT] = pk1;
        status[psos_pkg::ST_PKP2_BIT] = pk2;
        status[psos_pkg::ST_PKP3_BIT] = pk3;
        status[psos_pkg::ST_PKP4_BIT] = pk4;
        status[psos_pkg::ST_ARMED_BIT] = armed;
        status[psos_pkg::ST_STATE_LSB +: 3] = q_q.st;
    end

    // Register read view, also the base for byte-lane merges
    assign boff = wb_adr_i - psos_pkg::OFS_BLD0;
    assign bld_hit = wb_adr_i >= psos_pkg::OFS_BLD0 && boff[1:0] == 2'h0
        && boff[7:2] < 6'(psos_pkg::NUM_BLD);

    always_comb
    begin
        rdv = 32'h0000_0000;
        case (wb_adr_i)
            psos_pkg::OFS_CTRL: rdv[psos_pkg::CTRL_W-1:0] = q_q.ctrl;
            psos_pkg::OFS_STATUS: rdv[15:0] = status;
            psos_pkg::OFS_DLY1P: rdv[15:0] = q_q.dly1p;
            psos_pkg::OFS_DLY1R: rdv[15:0] = q_q.dly1r;
            psos_pkg::OFS_DLY2P: rdv[15:0] = q_q.dly2p;
            psos_pkg::OFS_DLY3P: rdv[15:0] = q_q.dly3p;
            psos_pkg::OFS_DLY4P: rdv[15:0] = q_q.dly4p;
            psos_pkg::OFS_SEAL: rdv[15:0] = q_q.seal;
            psos_pkg::OFS_ANG_OUT: rdv[7:0] = q_q.ang_out;
            psos_pkg::OFS_ANG_MID: rdv[7:0] = q_q.ang_mid;
            psos_pkg::OFS_ANG_IN: rdv[7:0] = q_q.ang_in;
            default:
            begin
                if (bld_hit)
                begin
                    rdv[15:0] = q_q.bld[boff[4:2]];
                end
            end
        endcase
    end

    assign req = wb_cyc_i & wb_stb_i;
    // Commit on the edge the master samples ack
    assign wr = req & q_q.ack & wb_we_i;
    assign wv = wmerge(rdv, wb_dat_i, wb_sel_i);

    always_comb
    begin
        q_d = q_q;
        q_d.trip = 1'b0;

        q_d.ack = req & ~q_q.ack;
        if (req & ~q_q.ack)
        begin
            q_d.rdat = rdv;
        end
        else if (!req)
        begin
            q_d.rdat = 32'h0000_0000;
        end

        q_d.tick = q_q.tick_cnt == psos_pkg::TICK_W'(TICK_CYCLES - 1);
        q_d.tick_cnt = q_d.tick ? '0 : q_q.tick_cnt + psos_pkg::TICK_W'(1);

        if (wr)
        begin
            case (wb_adr_i)
                psos_pkg::OFS_CTRL: q_d.ctrl = wv[psos_pkg::CTRL_W-1:0];
                psos_pkg::OFS_DLY1P: q_d.dly1p = wv[15:0];
                psos_pkg::OFS_DLY1R: q_d.dly1r = wv[15:0];
                psos_pkg::OFS_DLY2P: q_d.dly2p = wv[15:0];
                psos_pkg::OFS_DLY3P: q_d.dly3p = wv[15:0];
                psos_pkg::OFS_DLY4P: q_d.dly4p = wv[15:0];
                psos_pkg::OFS_SEAL: q_d.seal = wv[15:0];
                psos_pkg::OFS_ANG_OUT:
                begin
                    if (wv[7:0] >= psos_pkg::ANG_MIN && wv[7:0] <= psos_pkg::ANG_MAX)
                    begin
                        q_d.ang_out = wv[7:0];
                    end
                end
                psos_pkg::OFS_ANG_MID:
                begin
                    if (wv[7:0] >= psos_pkg::ANG_MIN && wv[7:0] <= psos_pkg::ANG_MAX)
                    begin
                        q_d.ang_mid = wv[7:0];
                    end
                end
                psos_pkg::OFS_ANG_IN:
                begin
                    if (wv[7:0] >= psos_pkg::ANG_MIN && wv[7:0] <= psos_pkg::ANG_MAX)
                    begin
                        q_d.ang_in = wv[7:0];
                    end
                end
                default:
                begin
                    if (bld_hit && wv[15:0] >= psos_pkg::BLD_MIN && wv[15:0] <= psos_pkg::BLD_MAX)
                    begin
                        q_d.bld[boff[4:2]] = wv[15:0];
                    end
                end
            endcase
        end

        q_d.t1 = tmr(band1, q_q.t1, q_q.tick);
        if (pk1)
        begin
            q_d.latch = 1'b1;
        end
        q_d.t1r = tmr(~z_out & q_q.latch, q_q.t1r, q_q.tick);
        if (~z_out && q_q.latch && q_q.t1r >= q_q.dly1r)
        begin
            q_d.latch = 1'b0;
            q_d.t1r = 16'h0000;
        end

        case (q_q.st)
            psos_pkg::S_IDLE:
            begin
                q_d.tseq = 16'h0000;
                if (pk1)
                begin
                    q_d.st = three ? psos_pkg::S_MID : psos_pkg::S_IN;
                end
            end
            psos_pkg::S_MID:
            begin
                q_d.tseq = tmr(band2, q_q.tseq, q_q.tick);
                if (!z_out)
                begin
                    q_d.st = psos_pkg::S_IDLE;
                end
                else if (pk2)
                begin
                    q_d.st = psos_pkg::S_IN;
                    q_d.tseq = 16'h0000;
                end
            end
            psos_pkg::S_IN:
            begin
                q_d.tseq = tmr(z_in, q_q.tseq, q_q.tick);
                if (!z_out)
                begin
                    q_d.st = psos_pkg::S_IDLE;
                end
                else if (pk3)
                begin
                    q_d.tseq = 16'h0000;
                    if (q_q.ctrl[psos_pkg::CTRL_EARLY_BIT])
                    begin
                        q_d.trip = 1'b1;
                        q_d.st = psos_pkg::S_IDLE;
                    end
                    else
                    begin
                        q_d.st = psos_pkg::S_ARM;
                    end
                end
            end
            psos_pkg::S_ARM:
            begin
                q_d.tseq = tmr(band4, q_q.tseq, q_q.tick);
                // Exit before the dwell completes gives no trip
                if (!z_out)
                begin
                    q_d.st = psos_pkg::S_IDLE;
                end
                else if (pk4)
                begin
                    q_d.st = psos_pkg::S_ARM_EXIT;
                    q_d.tseq = 16'h0000;
                end
            end
            psos_pkg::S_ARM_EXIT:
            begin
                q_d.tseq = 16'h0000;
                if (!z_out)
                begin
                    q_d.trip = 1'b1;
                    q_d.st = psos_pkg::S_IDLE;
                end
            end
            default:
            begin
                q_d.st = psos_pkg::S_IDLE;
                q_d.tseq = 16'h0000;
            end
        endcase

        if (q_q.trip)
        begin
            q_d.seal_on = 1'b1;
            q_d.tseal = 16'h0000;
        end
        else if (q_q.seal_on)
        begin
            q_d.tseal = tmr(1'b1, q_q.tseal, q_q.tick);
            if (q_q.tseal >= q_q.seal)
            begin
                q_d.seal_on = 1'b0;
            end
        end

        // disabled element holds all state idle
        if (!en)
        begin
            q_d.latch = 1'b0;
            q_d.t1 = 16'h0000;
            q_d.t1r = 16'h0000;
            q_d.tseq = 16'h0000;
            q_d.tseal = 16'h0000;
            q_d.seal_on = 1'b0;
            q_d.trip = 1'b0;
            q_d.st = psos_pkg::S_IDLE;
        end

        q_d.trip_out = en & ~block_in & (q_d.trip | q_d.seal_on);

        q_d.evt_prev = status[psos_pkg::EVT_W-1:0];
        q_d.evt_valid = q_q.ctrl[psos_pkg::CTRL_EVT_BIT] && status[psos_pkg::EVT_W-1:0] != q_q.evt_prev;
        q_d.evt_code = status[psos_pkg::EVT_W-1:0];

        if (srst)
        begin
            q_d = '0;
            q_d.ctrl = psos_pkg::CTRL_RST;
            q_d.dly1p = psos_pkg::DLY1P_RST;
            q_d.dly1r = psos_pkg::DLY1R_RST;
            q_d.dly2p = psos_pkg::DLY2P_RST;
            q_d.dly3p = psos_pkg::DLY3P_RST;
            q_d.dly4p = psos_pkg::DLY4P_RST;
            q_d.seal = psos_pkg::SEAL_RST;
            q_d.ang_out = psos_pkg::ANG_OUT_RST;
            q_d.ang_mid = psos_pkg::ANG_MID_RST;
            q_d.ang_in = psos_pkg::ANG_IN_RST;
            for (int k = 0; k < psos_pkg::NUM_BLD; k++)
            begin
                q_d.bld[k] = psos_pkg::BLD_RST;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        q_q <= q_d;
    end

    assign wb_ack_o = q_q.ack;
    assign wb_dat_o = q_q.rdat;
    assign swing_block = q_q.latch;
    assign oos_trip = q_q.trip_out;
    assign evt_valid = q_q.evt_valid;
    assign evt_code = q_q.evt_code;
    assign shape_quad = q_q.ctrl[psos_pkg::CTRL_QUAD_BIT];
    // apple above right angle, lens otherwise
    assign outer_apple = q_q.ang_out > psos_pkg::ANG_RIGHT;
    assign ang_outer = q_q.ang_out;
    assign ang_middle = q_q.ang_mid;
    assign ang_inner = q_q.ang_in;
    assign blinder_reach = q_q.bld;

endmodule

`default_nettype wire

// *** test/psos_zone_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module psos_zone_model (
    input wire logic mclk,
    input wire logic [1:0] pos,
    output logic zone_outer = 1'b0,
    output logic zone_middle = 1'b0,
    output logic zone_inner = 1'b0
);
    // Flags change only on the clock
    always_ff @(posedge mclk)
    begin
        zone_outer <= pos != 2'h0;
        zone_middle <= pos[1];
        zone_inner <= pos == 2'h3;
    end
endmodule
`default_nettype wire

// *** test/psos_seq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module psos_seq_sva #(
    parameter int TICK_CYCLES = psos_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_ack_o,
    input wire logic zone_outer,
    input wire logic zone_inner,
    input wire logic supv_ok,
    input wire logic block_in,
    input wire logic swing_block,
    input wire logic oos_trip,
    input wire logic evt_valid,
    input wire logic outer_apple,
    input wire logic [7:0] ang_outer
);
    localparam int D1_MIN = (int'(psos_pkg::DLY1P_RST) - 1) * TICK_CYCLES;
    localparam int D1R_MIN = (int'(psos_pkg::DLY1R_RST) - 1) * TICK_CYCLES;
    localparam int SEAL_MIN = (int'(psos_pkg::SEAL_RST) - 1) * TICK_CYCLES;
    logic [4:0] ctrl_q;
    int in_cnt;
    int out_cnt;
    int trip_cnt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // Shadow of control; timer settings assumed left at defaults
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_q <= psos_pkg::CTRL_RST;
            in_cnt <= 0;
            out_cnt <= 0;
            trip_cnt <= 0;
        end
        else
        begin
            if (wb_ack_o && wb_we_i && wb_adr_i == psos_pkg::OFS_CTRL && wb_sel_i[0])
            begin
                ctrl_q <= wb_dat_i[4:0];
            end
            in_cnt <= (zone_outer && supv_ok) ? in_cnt + 1 : 0;
            out_cnt <= (zone_outer && supv_ok) ? 0 : out_cnt + 1;
            trip_cnt <= oos_trip ? trip_cnt + 1 : 0;
        end
    end
    property p_latch_set;
        $rose(swing_block) |-> in_cnt >= D1_MIN;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch set early");
    property p_latch_clr;
        $fell(swing_block) && ctrl_q[0] |-> out_cnt >= D1R_MIN;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch cleared early");
    property p_delay_trip;
        $rose(oos_trip) && !ctrl_q[2] |-> $past(!zone_outer);
    endproperty
    a_delay_trip: assert property (p_delay_trip) else $error("delayed trip inside outer");
    property p_early_trip;
        $rose(oos_trip) && ctrl_q[2] |-> zone_inner;
    endproperty
    a_early_trip: assert property (p_early_trip) else $error("early trip outside inner");
    property p_seal;
        $fell(oos_trip) && $past(ctrl_q[0]) && !$past(block_in) |-> trip_cnt >= SEAL_MIN;
    endproperty
    a_seal: assert property (p_seal) else $error("trip shorter than seal");
    property p_block;
        block_in |=> !oos_trip;
    endproperty
    a_block: assert property (p_block) else $error("trip while blocked");
    property p_evt_off;
        !ctrl_q[3] [*2] |-> !evt_valid;
    endproperty
    a_evt_off: assert property (p_evt_off) else $error("event while logging off");
    property p_disabled;
        !ctrl_q[0] [*3] |-> !swing_block && !oos_trip;
    endproperty
    a_disabled: assert property (p_disabled) else $error("output while disabled");
    property p_apple;
        $stable(ang_outer) |-> outer_apple == (ang_outer > psos_pkg::ANG_RIGHT);
    endproperty
    a_apple: assert property (p_apple) else $error("outer shape wrong");
    c_latch: cover property ($rose(swing_block));
    c_trip: cover property ($rose(oos_trip));
    c_evt: cover property (evt_valid);
endmodule
bind psos_seq psos_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (
    .mclk, .srst, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .zone_outer, .zone_inner,
    .supv_ok, .block_in, .swing_block, .oos_trip, .evt_valid, .outer_apple, .ang_outer
);
`default_nettype wire

// *** test/psos_seq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module psos_seq_tb_top;
    localparam int T = 10;
    localparam logic [7:0] CT = psos_pkg::OFS_CTRL;
    localparam logic [7:0] ST = psos_pkg::OFS_STATUS;
    localparam logic [31:0] SM = 32'h00000700;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic supv = 1'b1;
    logic blk = 1'b0;
    logic [1:0] pos = 2'h0;
    logic [31:0] rdat;
    logic [31:0] dout;
    logic ack, zo, zm, zi, sb, trip, ev, quad, apple;
    logic [7:0] evc, ao, am, ai;
    logic [5:0][15:0] bld;
    int error_cnt = 0;
    int checked = 0;
    int evt_n = 0;
    logic [7:0] evc_last = 8'h00;
    psos_zone_model zm_u (.mclk(mclk), .pos(pos), .zone_outer(zo), .zone_middle(zm), .zone_inner(zi));
    psos_seq #(.TICK_CYCLES(T)) dut_u (
        .mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dout), .wb_ack_o(ack), .zone_outer(zo),
        .zone_middle(zm), .zone_inner(zi), .supv_ok(supv), .block_in(blk), .swing_block(sb),
        .oos_trip(trip), .evt_valid(ev), .evt_code(evc), .shape_quad(quad), .outer_apple(apple),
        .ang_outer(ao), .ang_middle(am), .ang_inner(ai), .blinder_reach(bld)
    );
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        if (ev === 1'b1)
        begin
            evt_n++;
            evc_last = evc;
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        rdat = dout;
        cyc <= 1'b0;
        if (ack !== 1'b1)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (2) @(posedge mclk);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h00000000);
        chk(nm, rdat & m, e);
    endtask
    task automatic go(input logic [1:0] p, input int ticks);
        pos <= p;
        repeat (ticks * T) @(posedge mclk);
    endtask
    task automatic t_regs();
        rdm(CT, 32'h0000001F, 32'(psos_pkg::CTRL_RST), "ctrl");
        rdm(psos_pkg::OFS_DLY1P, 32'h0000FFFF, 32'(psos_pkg::DLY1P_RST), "dly1");
        rdm(psos_pkg::OFS_SEAL, 32'h0000FFFF, 32'(psos_pkg::SEAL_RST), "seal");
        rdm(8'hFC, 32'hFFFFFFFF, 32'h00000000, "unmapped");
        wr(ST, 32'hFFFFFFFF);
        rdm(ST, 32'hFFFFFFFF, 32'h00000000, "status ro");
        chk("ang in", ai, psos_pkg::ANG_IN_RST);
        chk("ang mid", am, psos_pkg::ANG_MID_RST);
        wr(psos_pkg::OFS_ANG_MID, 32'h00000027);
        chk("mid low", am, psos_pkg::ANG_MID_RST);
        wr(psos_pkg::OFS_ANG_MID, 32'h0000008C);
        wr(psos_pkg::OFS_ANG_MID, 32'h0000008D);
        chk("mid max", am, 8'h8C);
        chk("apple rst", apple, 1'b1);
        wr(psos_pkg::OFS_ANG_OUT, 32'h00000050);
        chk("lens", apple, 1'b0);
        chk("ang out", ao, 8'h50);
        for (int i = 0; i < psos_pkg::NUM_BLD; i++)
        begin
            wr(psos_pkg::OFS_BLD0 + 8'(4 * i), 32'(psos_pkg::BLD_MIN - 16'h0001));
            chk("bld low", bld[i], psos_pkg::BLD_RST);
            wr(psos_pkg::OFS_BLD0 + 8'(4 * i), 32'(psos_pkg::BLD_MAX));
            chk("bld max", bld[i], psos_pkg::BLD_MAX);
        end
        wr(psos_pkg::OFS_BLD0, 32'(psos_pkg::BLD_MAX + 16'h0001));
        chk("bld high", bld[0], psos_pkg::BLD_MAX);
        wr(CT, 32'h00000018);
        chk("quad", quad, 1'b1);
    endtask
    task automatic t_two();
        wr(CT, 32'h00000009);
        go(2'h2, 28);
        chk("latch early", sb, 1'b0);
        go(2'h2, 4);
        chk("latch", sb, 1'b1);
        chk("evt code", evc_last, 8'h09);
        go(2'h3, 7);
        rdm(ST, 32'h00000080, 32'h00000000, "arm early");
        go(2'h3, 3);
        rdm(ST, 32'h00000080, 32'h00000080, "armed");
        go(2'h2, 15);
        rdm(ST, SM, 32'h00000300, "arm wait");
        chk("no trip", trip, 1'b0);
        go(2'h2, 3);
        rdm(ST, SM, 32'h00000400, "arm exit");
        go(2'h0, 0);
        repeat (6) @(posedge mclk);
        chk("trip", trip, 1'b1);
        rdm(ST, SM, 32'h00000000, "idle");
        go(2'h0, 47);
        chk("latch held", sb, 1'b1);
        go(2'h0, 5);
        chk("latch clr", sb, 1'b0);
        go(2'h0, 345);
        chk("sealed", trip, 1'b1);
        go(2'h0, 5);
        chk("seal end", trip, 1'b0);
        chk("events", evt_n > 0, 1'b1);
    endtask
    task automatic t_three();
        int n0;
        wr(CT, 32'h00000007);
        n0 = evt_n;
        go(2'h1, 32);
        chk("latch 3", sb, 1'b1);
        go(2'h2, 15);
        rdm(ST, SM, 32'h00000100, "mid wait");
        go(2'h2, 3);
        rdm(ST, SM, 32'h00000200, "mid done");
        go(2'h3, 7);
        chk("trip early", trip, 1'b0);
        go(2'h3, 3);
        chk("early trip", trip, 1'b1);
        blk <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("blocked", trip, 1'b0);
        chk("swing kept", sb, 1'b1);
        rdm(ST, 32'h00000006, 32'h00000004, "seal runs");
        go(2'h0, 402);
        blk <= 1'b0;
        go(2'h0, 5);
        chk("trip off", trip, 1'b0);
        chk("no events", evt_n == n0, 1'b1);
    endtask
    task automatic t_gate();
        wr(CT, 32'h00000000);
        go(2'h1, 35);
        chk("disabled", sb, 1'b0);
        wr(CT, 32'h00000001);
        supv <= 1'b0;
        go(2'h1, 35);
        chk("unsupervised", sb, 1'b0);
        supv <= 1'b1;
        go(2'h1, 20);
        go(2'h0, 2);
        go(2'h1, 20);
        chk("restart", sb, 1'b0);
        go(2'h1, 12);
        chk("relatch", sb, 1'b1);
        wr(CT, 32'h00000000);
        go(2'h1, 1);
        chk("disable clr", sb, 1'b0);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_two();
        t_three();
        t_gate();
        end_of_test();
    end
endmodule
`default_nettype wire
